//--- rtl/cms_pkg.sv
// Functional notes
// RULE1: unsigned multiply, product into register pair
// RULE2: unsigned divide pair, quotient then remainder
// RULE3: equal flag when source ones in destination
// RULE4: serial count field zero means sixteen bits
// RULE5: serial address from R12, incremented, R12 kept
// RULE6: counts up to eight use byte operand
// RULE7: autoincrement by one or two by count
// RULE8: load-to-serial sends bits, least significant first
// RULE9: store-from-serial fills from bit zero, zeroes rest
// RULE10: serial results set flags 0-2, parity if byte
// RULE11: last bit shifted out goes to carry
// RULE12: left shift sets overflow on one into sign
// RULE13: zero shift count taken from R0, else sixteen
// RULE14: left shift fills zeros, flags 0-4
// RULE15: logical right fills zeros, right shifts flags 0-3
// RULE16: circular right feeds low bit to top
// RULE17: context switch loads pointer, counter, saves old three
// RULE18: no interrupt sampling after context switch
// RULE19: absolute value flags from original operand
// RULE20: byte swap exchanges halves, status untouched
// RULE21: execute-indirect runs target, extra words at counter
// RULE22: acquisition output low for indirect target fetch
// RULE23: arithmetic right shift replicates the sign bit
package cms_pkg;
	localparam logic [5:0] OPC_COC = 6'h08;
	localparam logic [5:0] OPC_LOAD_TO_SERIAL_IO = 6'h0C;
	localparam logic [5:0] OPC_STORE_FROM_SERIAL_IO = 6'h0D;
	localparam logic [5:0] OPC_MPY = 6'h0E;
	localparam logic [5:0] OPC_DIV = 6'h0F;
	localparam logic [7:0] OPC_SRA = 8'h08;
	localparam logic [7:0] OPC_SRL = 8'h09;
	localparam logic [7:0] OPC_SLA = 8'h0A;
	localparam logic [7:0] OPC_SRC = 8'h0B;
	localparam logic [9:0] OPC_CONTEXT_SWITCH_BRANCH = 10'h010;
	localparam logic [9:0] OPC_X = 10'h012;
	localparam logic [9:0] OPC_BYTE_SWAP_OP = 10'h01B;
	localparam logic [9:0] OPC_ABS = 10'h01D;
	// status register positions, msb is status bit 0
	localparam int ST_LGT = 15;
	localparam int ST_AGT = 14;
	localparam int ST_EQ = 13;
	localparam int ST_C = 12;
	localparam int ST_OV = 11;
	localparam int ST_OP = 10;
	// register map, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PC = 8'h04;
	localparam logic [7:0] REG_WP = 8'h08;
	localparam logic [7:0] REG_ST = 8'h0C;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam int MEM_SEL_BIT = 7;
	// workspace register byte offsets
	localparam logic [15:0] R12_OFF = 16'h0018;
	localparam logic [15:0] R13_OFF = 16'h001A;
	localparam logic [15:0] R14_OFF = 16'h001C;
	localparam logic [15:0] R15_OFF = 16'h001E;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] BYTE_STEP = 16'h0001;
	localparam logic [15:0] SIGN_MIN = 16'h8000;
	localparam logic [4:0] FULL_COUNT = 5'h10;
	localparam logic [4:0] BYTE_MAX = 5'h08;
	localparam logic [4:0] DIV_STEPS = 5'h10;
	typedef enum logic [3:0] {
		OP_COC, OP_MPY, OP_DIV, OP_LOAD_TO_SERIAL_IO, OP_STORE_FROM_SERIAL_IO, OP_SLA, OP_SRA,
		OP_SRL, OP_SRC, OP_CONTEXT_SWITCH_BRANCH, OP_X, OP_ABS, OP_BYTE_SWAP_OP, OP_BAD
	} cms_op_t;
	typedef enum logic [3:0] {
		S_IDLE, S_FETCH, S_DEC, S_XFETCH, S_EXEC, S_DIVW, S_WB2, S_SHIFT,
		S_SIO, S_SIOEND, S_BLWP1, S_BLWP2, S_BLWP3, S_DONE
	} cms_state_t;

	function automatic cms_op_t decode(input logic [15:0] ir);
		cms_op_t op;
		op = OP_BAD;
		case (ir[15:10])
			OPC_COC: op = OP_COC;
			OPC_LOAD_TO_SERIAL_IO: op = OP_LOAD_TO_SERIAL_IO;
			OPC_STORE_FROM_SERIAL_IO: op = OP_STORE_FROM_SERIAL_IO;
			OPC_MPY: op = OP_MPY;
			OPC_DIV: op = OP_DIV;
			default: op = OP_BAD;
		endcase
		case (ir[15:8])
			OPC_SRA: op = OP_SRA;
			OPC_SRL: op = OP_SRL;
			OPC_SLA: op = OP_SLA;
			OPC_SRC: op = OP_SRC;
			default: ;
		endcase
		case (ir[15:6])
			OPC_CONTEXT_SWITCH_BRANCH: op = OP_CONTEXT_SWITCH_BRANCH;
			OPC_X: op = OP_X;
			OPC_BYTE_SWAP_OP: op = OP_BYTE_SWAP_OP;
			OPC_ABS: op = OP_ABS;
			default: ;
		endcase
		return op;
	endfunction : decode

	// {logical gt, arithmetic gt, equal} against zero
	function automatic logic [2:0] cmp0(input logic [15:0] v);
		return {v != 16'h0000, !v[15] && (v != 16'h0000), v == 16'h0000};
	endfunction : cmp0
endpackage : cms_pkg

//--- rtl/cms_divider.sv
`timescale 1ns/1ns
// restoring divider, one quotient bit per clock; caller guarantees no overflow
module cms_divider (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [31:0] dividend_i,
	input wire logic [15:0] divisor_i,
	output logic done_o,
	output logic [15:0] quo_o,
	output logic [15:0] rem_o
);
	logic [16:0] rem_r;
	logic [15:0] quo_r;
	logic [15:0] dvs_r;
	logic [4:0] n_r;
	logic done_r;
	logic [16:0] sh;

	assign sh = {rem_r[15:0], quo_r[15]};
	assign done_o = done_r;
	assign quo_o = quo_r;
	assign rem_o = rem_r[15:0];

	always_ff @(posedge clk_i)
	begin
		done_r <= 1'b0;
		if (rst_i)
		begin
			rem_r <= 17'h0_0000;
			quo_r <= 16'h0000;
			dvs_r <= 16'h0000;
			n_r <= 5'h00;
		end
		else if (start_i)
		begin
			rem_r <= {1'b0, dividend_i[31:16]};
			quo_r <= dividend_i[15:0];
			dvs_r <= divisor_i;
			n_r <= cms_pkg::DIV_STEPS;
		end
		else if (n_r != 5'h00)
		begin
			if (sh >= {1'b0, dvs_r})
			begin
				rem_r <= sh - {1'b0, dvs_r};
				quo_r <= {quo_r[14:0], 1'b1};
			end
			else
			begin
				rem_r <= sh;
				quo_r <= {quo_r[14:0], 1'b0};
			end
			n_r <= n_r - 5'h01;
			done_r <= (n_r == 5'h01);
		end
	end
endmodule : cms_divider

//--- rtl/cms_core.sv
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ns
module cms_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sio_din_i,
	output logic [11:0] sio_addr_o,
	output logic sio_dout_o,
	output logic sio_wr_o,
	output logic sio_rd_o,
	input wire logic interrupt_request_in_i,
	output logic int_take_o,
	output logic instruction_acquisition_o
);
	logic [15:0] mem_r [0:31];
	cms_pkg::cms_state_t state_r;
	cms_pkg::cms_op_t op_r;
	logic [15:0] ir_r, pc_r, wp_r, st_r, ea_r, opnd_r, res2_r, newwp_r, newpc_r;
	logic [4:0] idx2_r, cnt_r, bit_r;
	logic ph_r, byte_r, c_r, ov_r, iaq_r, take_r;
	logic ack_r, step_r, run_r, illegal_r, int_seen_r;
	logic [31:0] dat_r;
	logic [11:0] sio_addr_r;
	logic sio_dout_r, sio_wr_r, sio_rd_r;

	function automatic logic [4:0] widx(input logic [15:0] a);
		return a[5:1];
	endfunction : widx

	function automatic logic [15:0] lanes(input logic [15:0] o, input logic [15:0] n,
		input logic [1:0] s);
		return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
	endfunction : lanes

	cms_pkg::cms_op_t dec_op;
	logic [15:0] sreg_a, dreg_a, dreg1_a, sreg_v, ea_word, src, dst, ea_calc, abs_v;
	logic [15:0] store_from_serial_io_word, res_v;
	logic [31:0] prod;
	logic [4:0] sio_n, sh_n;
	logic is_shift, dec_byte, div_ovf, div_start, div_done, cw_en;
	logic [4:0] cw_idx;
	logic [15:0] cw_dat, quo, rem;
	logic wb_req, wb_commit, idle;

	assign dec_op = cms_pkg::decode(ir_r);
	assign is_shift = dec_op inside {cms_pkg::OP_SLA, cms_pkg::OP_SRA, cms_pkg::OP_SRL,
		cms_pkg::OP_SRC};
	assign sreg_a = wp_r + {11'h000, ir_r[3:0], 1'b0};
	assign dreg_a = wp_r + {11'h000, ir_r[9:6], 1'b0};
	assign dreg1_a = dreg_a + cms_pkg::WORD_STEP;
	assign sreg_v = mem_r[widx(sreg_a)];
	assign ea_word = mem_r[widx(ea_r)];
	// RULE6: byte operand select
	assign src = byte_r ? {8'h00, ea_r[0] ? ea_word[7:0] : ea_word[15:8]} : ea_word;
	assign dst = mem_r[widx(dreg_a)];
	// RULE1: unsigned product
	assign prod = {16'h0000, dst} * {16'h0000, src};
	assign div_ovf = src <= dst;
	// RULE4: zero count is sixteen
	assign sio_n = (ir_r[9:6] == 4'h0) ? cms_pkg::FULL_COUNT : {1'b0, ir_r[9:6]};
	assign dec_byte = sio_n <= cms_pkg::BYTE_MAX;
	// RULE13: count from R0 low nibble, else sixteen
	assign sh_n = (ir_r[7:4] != 4'h0) ? {1'b0, ir_r[7:4]} :
		(mem_r[widx(wp_r)][3:0] != 4'h0) ? {1'b0, mem_r[widx(wp_r)][3:0]} :
		cms_pkg::FULL_COUNT;
	assign abs_v = src[15] ? 16'h0000 - src : src;
	// RULE9: stored byte merged into its half
	assign store_from_serial_io_word = !byte_r ? opnd_r : ea_r[0] ? {ea_word[15:8], opnd_r[7:0]} :
		{opnd_r[7:0], ea_word[7:0]};
	assign res_v = byte_r ? {{8{opnd_r[7]}}, opnd_r[7:0]} : opnd_r;
	assign div_start = (state_r == cms_pkg::S_EXEC) && (op_r == cms_pkg::OP_DIV) && !div_ovf;
	assign idle = state_r == cms_pkg::S_IDLE;
	assign wb_req = wb_cyc_i && wb_stb_i;
	// a write lands on the edge where ack is seen high
	assign wb_commit = wb_req && wb_we_i && ack_r;

	always_comb
	begin
		case (ir_r[5:4])
			2'b00: ea_calc = sreg_a;
			2'b10: ea_calc = mem_r[widx(pc_r)] + ((ir_r[3:0] == 4'h0) ? 16'h0000 : sreg_v);
			default: ea_calc = sreg_v;
		endcase
	end

	always_comb
	begin
		cw_en = 1'b0;
		cw_idx = widx(ea_r);
		cw_dat = opnd_r;
		case (state_r)
			cms_pkg::S_DEC:
			begin
				// RULE7: autoincrement by operand size
				cw_en = (ir_r[5:4] == 2'b11) && !is_shift && (dec_op != cms_pkg::OP_BAD);
				cw_idx = widx(sreg_a);
				cw_dat = sreg_v + ((dec_op inside {cms_pkg::OP_LOAD_TO_SERIAL_IO, cms_pkg::OP_STORE_FROM_SERIAL_IO}
					&& dec_byte) ? cms_pkg::BYTE_STEP : cms_pkg::WORD_STEP);
			end
			cms_pkg::S_EXEC:
			begin
				cw_en = op_r inside {cms_pkg::OP_MPY, cms_pkg::OP_ABS, cms_pkg::OP_BYTE_SWAP_OP};
				cw_idx = (op_r == cms_pkg::OP_MPY) ? widx(dreg_a) : widx(ea_r);
				// RULE20: halves exchanged
				cw_dat = (op_r == cms_pkg::OP_MPY) ? prod[31:16] :
					(op_r == cms_pkg::OP_ABS) ? abs_v : {ea_word[7:0], ea_word[15:8]};
			end
			cms_pkg::S_DIVW:
			begin
				// RULE2: quotient into destination
				cw_en = div_done;
				cw_idx = widx(dreg_a);
				cw_dat = quo;
			end
			cms_pkg::S_WB2:
			begin
				cw_en = 1'b1;
				cw_idx = idx2_r;
				cw_dat = res2_r;
			end
			cms_pkg::S_SHIFT: cw_en = cnt_r == 5'h00;
			cms_pkg::S_SIOEND:
			begin
				cw_en = op_r == cms_pkg::OP_STORE_FROM_SERIAL_IO;
				cw_dat = store_from_serial_io_word;
			end
			cms_pkg::S_BLWP1:
			begin
				// RULE17: old pointer, counter, status saved in new R13-R15
				cw_en = 1'b1;
				cw_idx = widx(ea_word + cms_pkg::R13_OFF);
				cw_dat = wp_r;
			end
			cms_pkg::S_BLWP2:
			begin
				cw_en = 1'b1;
				cw_idx = widx(newwp_r + cms_pkg::R14_OFF);
				cw_dat = pc_r;
			end
			cms_pkg::S_BLWP3:
			begin
				cw_en = 1'b1;
				cw_idx = widx(newwp_r + cms_pkg::R15_OFF);
				cw_dat = st_r;
			end
			default: cw_en = 1'b0;
		endcase
	end

	cms_divider u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(div_start),
		.dividend_i({dst, mem_r[widx(dreg1_a)]}),
		.divisor_i(src),
		.done_o(div_done),
		.quo_o(quo),
		.rem_o(rem)
	);

	// memory: the core owns the write port while an instruction runs
	always_ff @(posedge clk_i)
	begin
		if (cw_en)
			mem_r[cw_idx] <= cw_dat;
		else if (wb_commit && wb_adr_i[cms_pkg::MEM_SEL_BIT] && idle)
			mem_r[wb_adr_i[6:2]] <= lanes(mem_r[wb_adr_i[6:2]], wb_dat_i[15:0], wb_sel_i[1:0]);
	end

	// sequencer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= cms_pkg::S_IDLE;
			op_r <= cms_pkg::OP_BAD;
			{ir_r, pc_r, wp_r, st_r, ea_r, opnd_r, res2_r, newwp_r, newpc_r} <= '0;
			{idx2_r, cnt_r, bit_r} <= '0;
			{ph_r, byte_r, c_r, ov_r, iaq_r} <= '0;
		end
		else
		begin
			case (state_r)
				cms_pkg::S_IDLE:
				begin
					if (step_r || run_r)
					begin
						state_r <= cms_pkg::S_FETCH;
						iaq_r <= 1'b1;
					end
					if (wb_commit && wb_adr_i == cms_pkg::REG_PC)
						pc_r <= wb_dat_i[15:0];
					if (wb_commit && wb_adr_i == cms_pkg::REG_WP)
						wp_r <= wb_dat_i[15:0];
					if (wb_commit && wb_adr_i == cms_pkg::REG_ST)
						st_r <= wb_dat_i[15:0];
				end
				cms_pkg::S_FETCH:
				begin
					ir_r <= mem_r[widx(pc_r)];
					pc_r <= pc_r + cms_pkg::WORD_STEP;
					iaq_r <= 1'b0;
					state_r <= cms_pkg::S_DEC;
				end
				cms_pkg::S_DEC:
				begin
					op_r <= dec_op;
					byte_r <= (dec_op inside {cms_pkg::OP_LOAD_TO_SERIAL_IO, cms_pkg::OP_STORE_FROM_SERIAL_IO}) && dec_byte;
					bit_r <= 5'h00;
					ph_r <= 1'b0;
					{c_r, ov_r} <= 2'b00;
					if (dec_op == cms_pkg::OP_BAD)
						state_r <= cms_pkg::S_DONE;
					else if (is_shift)
					begin
						ea_r <= sreg_a;
						opnd_r <= sreg_v;
						cnt_r <= sh_n;
						state_r <= cms_pkg::S_SHIFT;
					end
					else
					begin
						ea_r <= ea_calc;
						cnt_r <= sio_n;
						// RULE21: extra operand words come from the counter
						if (ir_r[5:4] == 2'b10)
							pc_r <= pc_r + cms_pkg::WORD_STEP;
						state_r <= (dec_op == cms_pkg::OP_X) ? cms_pkg::S_XFETCH :
							(dec_op == cms_pkg::OP_CONTEXT_SWITCH_BRANCH) ? cms_pkg::S_BLWP1 : cms_pkg::S_EXEC;
					end
				end
				cms_pkg::S_XFETCH:
				begin
					// RULE22: target fetched with acquisition low
					ir_r <= ea_word;
					state_r <= cms_pkg::S_DEC;
				end
				cms_pkg::S_EXEC:
				begin
					state_r <= cms_pkg::S_DONE;
					case (op_r)
						// RULE3: ones of source present in destination
						cms_pkg::OP_COC: st_r[cms_pkg::ST_EQ] <= (src & dst) == src;
						cms_pkg::OP_MPY:
						begin
							res2_r <= prod[15:0];
							idx2_r <= widx(dreg1_a);
							state_r <= cms_pkg::S_WB2;
						end
						cms_pkg::OP_DIV:
						begin
							st_r[cms_pkg::ST_OV] <= div_ovf;
							if (!div_ovf)
								state_r <= cms_pkg::S_DIVW;
						end
						cms_pkg::OP_LOAD_TO_SERIAL_IO, cms_pkg::OP_STORE_FROM_SERIAL_IO:
						begin
							opnd_r <= (op_r == cms_pkg::OP_LOAD_TO_SERIAL_IO) ? src : 16'h0000;
							state_r <= cms_pkg::S_SIO;
						end
						cms_pkg::OP_ABS:
						begin
							// RULE19: flags from the operand before it changes
							st_r[cms_pkg::ST_LGT:cms_pkg::ST_EQ] <= cms_pkg::cmp0(src);
							st_r[cms_pkg::ST_C] <= 1'b0;
							st_r[cms_pkg::ST_OV] <= src == cms_pkg::SIGN_MIN;
						end
						default: ;
					endcase
				end
				cms_pkg::S_DIVW:
					if (div_done)
					begin
						res2_r <= rem;
						idx2_r <= widx(dreg1_a);
						state_r <= cms_pkg::S_WB2;
					end
				cms_pkg::S_WB2: state_r <= cms_pkg::S_DONE;
				cms_pkg::S_SHIFT:
					if (cnt_r != 5'h00)
					begin
						cnt_r <= cnt_r - 5'h01;
						// RULE11: carry tracks the bit leaving
						c_r <= (op_r == cms_pkg::OP_SLA) ? opnd_r[15] : opnd_r[0];
						case (op_r)
							// RULE14: zero fill from the right
							cms_pkg::OP_SLA: opnd_r <= {opnd_r[14:0], 1'b0};
							// RULE23: sign copied in
							cms_pkg::OP_SRA: opnd_r <= {opnd_r[15], opnd_r[15:1]};
							// RULE16: low bit wraps to the top
							cms_pkg::OP_SRC: opnd_r <= {opnd_r[0], opnd_r[15:1]};
							// RULE15: zero fill from the left
							default: opnd_r <= {1'b0, opnd_r[15:1]};
						endcase
						// RULE12: a one entering the sign bit
						if (opnd_r[14])
							ov_r <= 1'b1;
					end
					else
					begin
						st_r[cms_pkg::ST_LGT:cms_pkg::ST_EQ] <= cms_pkg::cmp0(opnd_r);
						st_r[cms_pkg::ST_C] <= c_r;
						if (op_r == cms_pkg::OP_SLA)
							st_r[cms_pkg::ST_OV] <= ov_r;
						state_r <= cms_pkg::S_DONE;
					end
				cms_pkg::S_SIO:
				begin
					ph_r <= !ph_r;
					if (ph_r)
					begin
						if (op_r == cms_pkg::OP_STORE_FROM_SERIAL_IO)
							opnd_r[bit_r[3:0]] <= sio_din_i;
						bit_r <= bit_r + 5'h01;
						if (bit_r + 5'h01 == cnt_r)
							state_r <= cms_pkg::S_SIOEND;
					end
				end
				cms_pkg::S_SIOEND:
				begin
					// RULE10: compare to zero, parity only for byte counts
					st_r[cms_pkg::ST_LGT:cms_pkg::ST_EQ] <= cms_pkg::cmp0(res_v);
					if (byte_r)
						st_r[cms_pkg::ST_OP] <= ^opnd_r[7:0];
					state_r <= cms_pkg::S_DONE;
				end
				cms_pkg::S_BLWP1:
				begin
					newwp_r <= ea_word;
					newpc_r <= mem_r[widx(ea_r + cms_pkg::WORD_STEP)];
					state_r <= cms_pkg::S_BLWP2;
				end
				cms_pkg::S_BLWP2: state_r <= cms_pkg::S_BLWP3;
				cms_pkg::S_BLWP3:
				begin
					wp_r <= newwp_r;
					pc_r <= newpc_r;
					state_r <= cms_pkg::S_DONE;
				end
				cms_pkg::S_DONE:
				begin
					state_r <= run_r ? cms_pkg::S_FETCH : cms_pkg::S_IDLE;
					iaq_r <= run_r;
				end
				default: state_r <= cms_pkg::S_IDLE;
			endcase
		end
	end

	// serial port: address and data registered, sampled in the following cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			{sio_addr_r, sio_dout_r, sio_wr_r, sio_rd_r} <= '0;
		end
		else
		begin
			sio_wr_r <= 1'b0;
			sio_rd_r <= 1'b0;
			if (state_r == cms_pkg::S_SIO && !ph_r)
			begin
				// RULE5: base from R12, one step per bit, R12 untouched
				sio_addr_r <= mem_r[widx(wp_r + cms_pkg::R12_OFF)][12:1] + {7'h00, bit_r};
				// RULE8: least significant bit first
				sio_dout_r <= opnd_r[bit_r[3:0]];
				sio_wr_r <= op_r == cms_pkg::OP_LOAD_TO_SERIAL_IO;
				sio_rd_r <= op_r == cms_pkg::OP_STORE_FROM_SERIAL_IO;
			end
		end
	end

	// interrupt sampling at instruction end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			take_r <= 1'b0;
		else if (state_r == cms_pkg::S_DONE)
		begin
			// RULE18: no sample at the end of a context switch itself
			take_r <= interrupt_request_in_i && (op_r != cms_pkg::OP_CONTEXT_SWITCH_BRANCH);
		end
		else
			take_r <= 1'b0;
	end

	// bus slave and control bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			{ack_r, step_r, run_r, illegal_r, int_seen_r, dat_r} <= '0;
		else
		begin
			ack_r <= wb_req && !ack_r;
			if (wb_req && !ack_r)
			begin
				if (wb_adr_i[cms_pkg::MEM_SEL_BIT])
					dat_r <= {16'h0000, mem_r[wb_adr_i[6:2]]};
				else
					case (wb_adr_i)
						cms_pkg::REG_CTRL: dat_r <= {31'h0000_0000, run_r};
						cms_pkg::REG_PC: dat_r <= {16'h0000, pc_r};
						cms_pkg::REG_WP: dat_r <= {16'h0000, wp_r};
						cms_pkg::REG_ST: dat_r <= {16'h0000, st_r};
						cms_pkg::REG_STAT: dat_r <= {29'h0000_0000, !idle, int_seen_r, illegal_r};
						default: dat_r <= 32'h0000_0000;
					endcase
			end
			if (wb_commit && wb_adr_i == cms_pkg::REG_CTRL)
			begin
				run_r <= wb_dat_i[1];
				step_r <= wb_dat_i[0];
			end
			else if (idle)
				step_r <= 1'b0;
			// flags: hardware set wins over write-one-to-clear
			illegal_r <= (state_r == cms_pkg::S_DEC && dec_op == cms_pkg::OP_BAD) ||
				(illegal_r && !(wb_commit && wb_adr_i == cms_pkg::REG_STAT && wb_dat_i[0]));
			int_seen_r <= take_r ||
				(int_seen_r && !(wb_commit && wb_adr_i == cms_pkg::REG_STAT && wb_dat_i[1]));
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign sio_addr_o = sio_addr_r;
	assign sio_dout_o = sio_dout_r;
	assign sio_wr_o = sio_wr_r;
	assign sio_rd_o = sio_rd_r;
	assign int_take_o = take_r;
	assign instruction_acquisition_o = iaq_r;

	sequence sio_bit_s;
		sio_wr_o || sio_rd_o;
	endsequence
	sequence sio_next_s;
		sio_bit_s ##2 sio_bit_s;
	endsequence

	AST_BYTE_SWAP_OP_KEEPS_ST: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
		(state_r == cms_pkg::S_EXEC && op_r == cms_pkg::OP_BYTE_SWAP_OP) |=> $stable(st_r))
		else $error("byte swap changed status");
	AST_X_NO_IAQ: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
		state_r == cms_pkg::S_XFETCH |-> !instruction_acquisition_o)
		else $error("acquisition high on indirect fetch");
	AST_CONTEXT_SWITCH_BRANCH_NO_INT: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
		(state_r == cms_pkg::S_DONE && op_r == cms_pkg::OP_CONTEXT_SWITCH_BRANCH) |=> !int_take_o)
		else $error("interrupt check after context switch");
	AST_SIO_STEP: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
		sio_next_s |-> sio_addr_o == $past(sio_addr_o, 2) + 12'h001)
		else $error("serial address did not step by one");
	AST_COC_EQ: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
		(state_r == cms_pkg::S_EXEC && op_r == cms_pkg::OP_COC) |=>
		st_r[cms_pkg::ST_EQ] == (($past(src) & $past(dst)) == $past(src)))
		else $error("equal flag wrong after compare-ones");
	AST_DIV_OVF: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
		(state_r == cms_pkg::S_EXEC && op_r == cms_pkg::OP_DIV && div_ovf) |=>
		st_r[cms_pkg::ST_OV] && state_r == cms_pkg::S_DONE)
		else $error("divide overflow not flagged");
	AST_SHIFT_COUNT: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
		(state_r == cms_pkg::S_SHIFT && $past(state_r) == cms_pkg::S_DEC) |->
		cnt_r != 5'h00 && cnt_r <= cms_pkg::FULL_COUNT)
		else $error("shift count out of range");
	AST_LOAD_TO_SERIAL_IO_LSB: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
		(state_r == cms_pkg::S_SIO && !ph_r && bit_r == 5'h00 && op_r == cms_pkg::OP_LOAD_TO_SERIAL_IO)
		|=> sio_wr_o && sio_dout_o == $past(opnd_r[0]))
		else $error("serial load did not start at bit zero");
	AST_MPY_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
		(state_r == cms_pkg::S_EXEC && op_r == cms_pkg::OP_MPY) |=>
		state_r == cms_pkg::S_WB2 && res2_r == $past(prod[15:0]))
		else $error("multiply low half not staged");
endmodule : cms_core

//--- sim/cms_sio_model.sv
`timescale 1ns/1ns
// serial i/o space peripheral: logs sent bits, answers reads from address
module cms_sio_model (
	input wire logic clk_i,
	input wire logic [11:0] sio_addr_i,
	input wire logic sio_dout_i,
	input wire logic sio_wr_i,
	input wire logic sio_rd_i,
	output logic sio_din_o
);
	logic [11:0] log_a [0:63];
	logic log_d [0:63];
	int n_wr = 0;
	int n_rd = 0;
	logic noise_r = 1'b0;
	// the bit answers while the read strobe stands, so the core samples it at the edge ending it
	assign sio_din_o = (sio_rd_i === 1'b1) ? ~sio_addr_i[0] : noise_r;
	always @(posedge clk_i)
	begin
		if (sio_wr_i === 1'b1)
		begin
			log_a[n_wr % 64] <= sio_addr_i;
			log_d[n_wr % 64] <= sio_dout_i;
			n_wr <= n_wr + 1;
		end
	end
	// toggling outside reads, so a stale bit is never mistaken for data
	always @(posedge clk_i)
	begin
		noise_r <= ~noise_r;
		if (sio_rd_i === 1'b1)
			n_rd <= n_rd + 1;
	end
endmodule : cms_sio_model

//--- sim/cms_core_bench.sv
`timescale 1ns/1ns
module cms_core_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic irq = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic [11:0] saddr;
	logic ack, din, dout, swr, srd, itake, instruction_acquisition;
	int failures = 0;
	int check_count = 0;
	int takes = 0;
	int acqs = 0;
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		takes <= takes + int'(itake === 1'b1);
		acqs <= acqs + int'(instruction_acquisition === 1'b1);
	end
	cms_core cms_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .sio_din_i(din), .sio_addr_o(saddr), .sio_dout_o(dout),
		.sio_wr_o(swr), .sio_rd_o(srd), .interrupt_request_in_i(irq), .int_take_o(itake),
		.instruction_acquisition_o(instruction_acquisition));
	cms_sio_model cms_sio_model_i (.clk_i(clk_i), .sio_addr_i(saddr), .sio_dout_i(dout),
		.sio_wr_i(swr), .sio_rd_i(srd), .sio_din_o(din));
	task wrap_up;
		$display("failures=%0d checks=%0d", failures, check_count);
		if (failures == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			failures++;
			wrap_up();
		end
	endtask : wb
	function automatic logic [7:0] ra(input int r);
		return 8'h80 + 8'(r * 4);
	endfunction : ra
	task automatic rw(input int r, input logic [15:0] v);
		logic [31:0] q;
		wb(1'b1, ra(r), v, q);
	endtask : rw
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		logic [31:0] q;
		wb(1'b0, a, 16'h0000, q);
		chk(q[15:0], e);
	endtask : rc
	// program at 0x0020, workspace at 0x0000, one step
	task automatic run(input logic [15:0] ins, input logic [15:0] st);
		logic [31:0] q;
		int n;
		rw(16, ins);
		wb(1'b1, cms_pkg::REG_PC, 16'h0020, q);
		wb(1'b1, cms_pkg::REG_WP, 16'h0000, q);
		wb(1'b1, cms_pkg::REG_ST, st, q);
		wb(1'b1, cms_pkg::REG_CTRL, 16'h0001, q);
		n = 0;
		do
		begin
			wb(1'b0, cms_pkg::REG_STAT, 16'h0000, q);
			n++;
		end
		while (q[2] !== 1'b0 && n < 100);
		if (q[2] !== 1'b0)
		begin
			failures++;
			wrap_up();
		end
	endtask : run
	task automatic t_arith;
		rw(2, 16'hFFFF);
		rw(3, 16'hFFFF);
		run(16'h38C2, 16'h0000);
		rc(ra(3), 16'hFFFE);
		rc(ra(4), 16'h0001);
		rw(2, 16'h0010);
		rw(3, 16'h0001);
		rw(4, 16'h0005);
		run(16'h3CC2, 16'h0000);
		rc(ra(3), 16'h1000);
		rc(ra(4), 16'h0005);
		rw(3, 16'h0020);
		run(16'h3CC2, 16'h0000);
		rc(cms_pkg::REG_ST, 16'h0800);
		rc(ra(3), 16'h0020);
		rw(2, 16'hAA0C);
		rw(3, 16'hEFCD);
		run(16'h20C2, 16'h0000);
		rc(cms_pkg::REG_ST, 16'h2000);
		rw(3, 16'hEFC9);
		run(16'h20C2, 16'h2000);
		rc(cms_pkg::REG_ST, 16'h0000);
	endtask : t_arith
	task automatic t_shift;
		logic [15:0] tb [0:4][0:4] = '{'{16'h0A15, 16'h0000, 16'h4001, 16'h8002, 16'h8800},
			'{16'h0805, 16'h0000, 16'h8000, 16'hFFFF, 16'h9000},
			'{16'h0945, 16'h0000, 16'h00F8, 16'h000F, 16'hD000},
			'{16'h0B45, 16'h0000, 16'h1234, 16'h4123, 16'hC000},
			'{16'h0905, 16'h0003, 16'h0010, 16'h0002, 16'hC000}};
		for (int i = 0; i < 5; i++)
		begin
			rw(0, tb[i][1]);
			rw(5, tb[i][2]);
			run(tb[i][0], 16'h0000);
			rc(ra(5), tb[i][3]);
			rc(cms_pkg::REG_ST, tb[i][4]);
		end
	endtask : t_shift
	task automatic t_sio;
		logic [15:0] tb [0:2][0:2] = '{'{16'h3703, 16'h0555, 16'hC400},
			'{16'h3403, 16'h5555, 16'hC400}, '{16'h3603, 16'h55FF, 16'hC000}};
		int cnt [0:2] = '{12, 16, 8};
		int n0;
		rw(2, 16'h0500);
		rw(12, 16'h0040);
		n0 = cms_sio_model_i.n_wr;
		run(16'h30C2, 16'h0000);
		chk(16'(cms_sio_model_i.n_wr - n0), 16'h0003);
		for (int i = 0; i < 3; i++)
		begin
			chk({4'h0, cms_sio_model_i.log_a[n0 + i]}, 16'h0020 + 16'(i));
			chk({15'h0000, cms_sio_model_i.log_d[n0 + i]}, 16'(~i & 1));
		end
		rc(ra(12), 16'h0040);
		rc(cms_pkg::REG_ST, 16'hC000);
		rw(2, 16'h0008);
		run(16'h30F2, 16'h0000);
		rc(ra(2), 16'h0009);
		rw(2, 16'h0008);
		run(16'h3032, 16'h0000);
		rc(ra(2), 16'h000A);
		for (int i = 0; i < 3; i++)
		begin
			rw(3, 16'hFFFF);
			n0 = cms_sio_model_i.n_rd;
			run(tb[i][0], 16'h0400);
			chk(16'(cms_sio_model_i.n_rd - n0), 16'(cnt[i]));
			rc(ra(3), tb[i][1]);
			rc(cms_pkg::REG_ST, tb[i][2]);
		end
	endtask : t_sio
	task automatic t_single;
		int k;
		rw(5, 16'h1234);
		run(16'h06C5, 16'hF000);
		rc(ra(5), 16'h3412);
		rc(cms_pkg::REG_ST, 16'hF000);
		rw(5, 16'hFFFE);
		run(16'h0745, 16'h1000);
		rc(ra(5), 16'h0002);
		rc(cms_pkg::REG_ST, 16'h8000);
		rw(5, 16'h06C6);
		rw(6, 16'h1234);
		k = acqs;
		run(16'h0485, 16'h0000);
		rc(ra(6), 16'h3412);
		chk(16'(acqs - k), 16'h0001);
	endtask : t_single
	task automatic t_switch;
		int k;
		rw(5, 16'h0010);
		rw(6, 16'h0030);
		irq <= 1'b1;
		k = takes;
		run(16'h0405, 16'hA000);
		rc(cms_pkg::REG_WP, 16'h0010);
		rc(cms_pkg::REG_PC, 16'h0030);
		rc(ra(21), 16'h0000);
		rc(ra(22), 16'h0022);
		rc(ra(23), 16'hA000);
		chk(16'(takes - k), 16'h0000);
		k = takes;
		run(16'h06C5, 16'h0000);
		rc(ra(5), 16'h1000);
		chk(16'(takes - k), 16'h0001);
		irq <= 1'b0;
	endtask : t_switch
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_arith();
		t_shift();
		t_sio();
		t_single();
		t_switch();
		wrap_up();
	end
endmodule : cms_core_bench
